// >>> mx_pkg.sv
package mx_pkg;

  // ****************************************
  // device constants
  // ****************************************
  localparam int         CH_N        = 2;
  localparam logic [6:0] TARGET_ADDR = 7'h70; // arbitrary default value
  localparam logic [7:0] SEL_RESET   = 8'h00;
  localparam int         SEL_EN_BIT  = 2;
  localparam int         SEL_INV_BIT = 1;
  localparam int         SEL_CH_BIT  = 0;
  localparam logic [3:0] BYTE_BITS   = 4'h8;
  localparam int         HOLD_W      = 3;

  // ****************************************
  // controller timing
  // ****************************************
  localparam int         CLK_HZ      = 50_000_000;
  localparam int         SCL_HZ      = 100_000;
  localparam int         QTR_CYC     = CLK_HZ / (4 * SCL_HZ);
  localparam logic [7:0] QTR_LAST    = 8'(QTR_CYC - 1);

  // ****************************************
  // controller register map
  // ****************************************
  localparam logic [3:0] WB_CTRL     = 4'h0;
  localparam logic [3:0] WB_STAT     = 4'h4;
  localparam logic [3:0] WB_ADDR     = 4'h8;
  localparam int         CTRL_GO     = 0;
  localparam int         CTRL_RD     = 1;
  localparam int         CTRL_CNT    = 4;
  localparam int         CTRL_WDATA  = 8;
  localparam int         STAT_BUSY   = 0;
  localparam int         STAT_NACK   = 1;
  localparam int         STAT_RDATA  = 8;

  typedef enum logic [6:0] {
    DS_IDLE = 7'h01,
    DS_ADDR = 7'h02,
    DS_AACK = 7'h04,
    DS_WR   = 7'h08,
    DS_WACK = 7'h10,
    DS_RD   = 7'h20,
    DS_RACK = 7'h40
  } mx_dev_state_e;

  typedef enum logic [3:0] {
    HS_IDLE  = 4'h1,
    HS_START = 4'h2,
    HS_BIT   = 4'h4,
    HS_STOP  = 4'h8
  } mx_host_state_e;

  // one-hot channel enable; never more than one bit set
  function automatic logic [CH_N-1:0] sel_decode(input logic [7:0] v);
    sel_decode = '0;
    if (v[SEL_EN_BIT] && !v[SEL_INV_BIT])
    begin
      sel_decode[v[SEL_CH_BIT]] = 1'b1;
    end
  endfunction

  // shift history; a line counts as ours while recently driven
  function automatic logic recent(input logic oe, input logic [HOLD_W-1:0] h);
    recent = oe | (|h);
  endfunction

endpackage

// >>> mx_link_if.sv
`timescale 1ns/1ps
interface mx_link_if;
  logic scl_h_oe;
  logic sda_h_oe;
  logic scl_d_oe;
  logic sda_d_oe;
  logic scl;
  logic sda;

  // open-drain wires with pull-ups
  assign scl = ~(scl_h_oe | scl_d_oe);
  assign sda = ~(sda_h_oe | sda_d_oe);

  modport host (output scl_h_oe, output sda_h_oe, input scl, input sda);
  modport dev  (output scl_d_oe, output sda_d_oe, input scl, input sda);
endinterface

// >>> mx_dev.sv
// The Wishbone register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module mx_dev
  import mx_pkg::*;
#(
  parameter logic [6:0] ADDR = mx_pkg::TARGET_ADDR
)(
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  mx_link_if.dev                     up,
  input  wire logic [mx_pkg::CH_N-1:0] downstream_clock_i,
  output logic      [mx_pkg::CH_N-1:0] downstream_clock_o,
  output logic      [mx_pkg::CH_N-1:0] downstream_clock_oe_o,
  input  wire logic [mx_pkg::CH_N-1:0] downstream_data_i,
  output logic      [mx_pkg::CH_N-1:0] downstream_data_o,
  output logic      [mx_pkg::CH_N-1:0] downstream_data_oe_o,
  output logic      [7:0]              channel_select_o,
  output logic      [mx_pkg::CH_N-1:0] active_o
);
  import mx_pkg::*;

  // ****************************************
  // synchronisers
  // ****************************************
  logic [2:0]      scl_sh_reg;
  logic [2:0]      sda_sh_reg;
  logic [CH_N-1:0] dclk_m_reg;
  logic [CH_N-1:0] dclk_s_reg;
  logic [CH_N-1:0] ddat_m_reg;
  logic [CH_N-1:0] ddat_s_reg;
  logic            scl_s;
  logic            scl_p;
  logic            sda_s;
  logic            sda_p;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      scl_sh_reg <= 3'h7;
      sda_sh_reg <= 3'h7;
      dclk_m_reg <= '1;
      dclk_s_reg <= '1;
      ddat_m_reg <= '1;
      ddat_s_reg <= '1;
    end
    else
    begin
      scl_sh_reg <= {scl_sh_reg[1:0], up.scl};
      sda_sh_reg <= {sda_sh_reg[1:0], up.sda};
      dclk_m_reg <= downstream_clock_i;
      dclk_s_reg <= dclk_m_reg;
      ddat_m_reg <= downstream_data_i;
      ddat_s_reg <= ddat_m_reg;
    end
  end

  assign scl_s = scl_sh_reg[1];
  assign scl_p = scl_sh_reg[2];
  assign sda_s = sda_sh_reg[1];
  assign sda_p = sda_sh_reg[2];

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_rise  = scl_s & ~scl_p;
  assign scl_fall  = ~scl_s & scl_p;
  assign start_det = scl_s & scl_p & sda_p & ~sda_s;
  assign stop_det  = scl_s & scl_p & ~sda_p & sda_s;

  // ****************************************
  // serial target
  // ****************************************
  mx_dev_state_e   state_reg;
  logic [3:0]      bit_reg;
  logic [7:0]      shift_reg;
  logic            rw_reg;
  logic            own_sda_reg;
  logic [7:0]      sel_reg;
  logic [CH_N-1:0] act_reg;

  // start and stop override any bit in flight
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg   <= DS_IDLE;
      bit_reg     <= '0;
      shift_reg   <= '0;
      rw_reg      <= 1'b0;
      own_sda_reg <= 1'b0;
    end
    else if (start_det)
    begin
      state_reg   <= DS_ADDR;
      bit_reg     <= '0;
      own_sda_reg <= 1'b0;
    end
    else if (stop_det)
    begin
      state_reg   <= DS_IDLE;
      own_sda_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        DS_ADDR, DS_WR:
        begin
          if (scl_rise)
          begin
            shift_reg <= {shift_reg[6:0], sda_s};
            bit_reg   <= bit_reg + 4'h1;
          end
          else if (scl_fall && bit_reg == BYTE_BITS)
          begin
            bit_reg <= '0;
            if (state_reg == DS_WR)
            begin
              own_sda_reg <= 1'b1;
              state_reg   <= DS_WACK;
            end
            else if (shift_reg[7:1] == ADDR)
            begin
              rw_reg      <= shift_reg[0];
              own_sda_reg <= 1'b1;
              state_reg   <= DS_AACK;
            end
            else
            begin
              state_reg <= DS_IDLE;
            end
          end
        end
        DS_AACK:
        begin
          if (scl_fall)
          begin
            bit_reg <= '0;
            if (rw_reg)
            begin
              own_sda_reg <= ~sel_reg[7];
              shift_reg   <= {sel_reg[6:0], 1'b0};
              state_reg   <= DS_RD;
            end
            else
            begin
              own_sda_reg <= 1'b0;
              state_reg   <= DS_WR;
            end
          end
        end
        DS_WACK:
        begin
          if (scl_fall)
          begin
            own_sda_reg <= 1'b0;
            state_reg   <= DS_WR;
          end
        end
        DS_RD:
        begin
          // data only changes after a falling clock
          if (scl_rise)
          begin
            bit_reg <= bit_reg + 4'h1;
          end
          else if (scl_fall)
          begin
            if (bit_reg == BYTE_BITS)
            begin
              own_sda_reg <= 1'b0;
              state_reg   <= DS_RACK;
            end
            else
            begin
              own_sda_reg <= ~shift_reg[7];
              shift_reg   <= {shift_reg[6:0], 1'b0};
            end
          end
        end
        DS_RACK:
        begin
          if (scl_rise)
          begin
            state_reg <= sda_s ? DS_IDLE : DS_AACK;
          end
        end
        default:
        begin
          state_reg <= DS_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // channel register
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sel_reg <= SEL_RESET;
      act_reg <= '0;
    end
    else
    begin
      if (!start_det && !stop_det && state_reg == DS_WR && scl_fall && bit_reg == BYTE_BITS)
      begin
        sel_reg <= shift_reg;
      end
      if (stop_det)
      begin
        act_reg <= sel_decode(sel_reg);
      end
    end
  end

  // ****************************************
  // pass-through
  // ****************************************
  // echo block: a line we pull low must not be mirrored back while
  // its synchronised copy still shows our own drive
  logic [CH_N-1:0]        dclk_oe_reg;
  logic [CH_N-1:0]        ddat_oe_reg;
  logic [HOLD_W-1:0]      dclk_h_reg [CH_N];
  logic [HOLD_W-1:0]      ddat_h_reg [CH_N];
  logic                   uclk_oe_reg;
  logic                   udat_oe_reg;
  logic [HOLD_W-1:0]      uclk_h_reg;
  logic [HOLD_W-1:0]      udat_h_reg;
  logic [CH_N-1:0]        pull_clk;
  logic [CH_N-1:0]        pull_dat;

  always_comb
  begin
    for (int k = 0; k < CH_N; k++)
    begin
      pull_clk[k] = act_reg[k] & ~dclk_s_reg[k] & ~recent(dclk_oe_reg[k], dclk_h_reg[k]);
      pull_dat[k] = act_reg[k] & ~ddat_s_reg[k] & ~recent(ddat_oe_reg[k], ddat_h_reg[k]);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dclk_oe_reg <= '0;
      ddat_oe_reg <= '0;
      uclk_oe_reg <= 1'b0;
      udat_oe_reg <= 1'b0;
      uclk_h_reg  <= '0;
      udat_h_reg  <= '0;
      for (int k = 0; k < CH_N; k++)
      begin
        dclk_h_reg[k] <= '0;
        ddat_h_reg[k] <= '0;
      end
    end
    else
    begin
      for (int k = 0; k < CH_N; k++)
      begin
        dclk_oe_reg[k] <= act_reg[k] & ~scl_s & ~recent(uclk_oe_reg, uclk_h_reg);
        ddat_oe_reg[k] <= act_reg[k] & ~sda_s &
                          ~recent(udat_oe_reg | own_sda_reg, udat_h_reg);
        dclk_h_reg[k]  <= {dclk_h_reg[k][HOLD_W-2:0], dclk_oe_reg[k]};
        ddat_h_reg[k]  <= {ddat_h_reg[k][HOLD_W-2:0], ddat_oe_reg[k]};
      end
      uclk_oe_reg <= |pull_clk;
      udat_oe_reg <= |pull_dat;
      uclk_h_reg  <= {uclk_h_reg[HOLD_W-2:0], uclk_oe_reg};
      udat_h_reg  <= {udat_h_reg[HOLD_W-2:0], udat_oe_reg | own_sda_reg};
    end
  end

  assign up.scl_d_oe            = uclk_oe_reg;
  assign up.sda_d_oe            = udat_oe_reg | own_sda_reg;
  assign downstream_clock_o     = '0;
  assign downstream_data_o      = '0;
  assign downstream_clock_oe_o  = dclk_oe_reg;
  assign downstream_data_oe_o   = ddat_oe_reg;
  assign channel_select_o       = sel_reg;
  assign active_o               = act_reg;

endmodule

// >>> mx_host.sv
`timescale 1ns/1ps
module mx_host
  import mx_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  mx_link_if.host          link
);
  import mx_pkg::*;

  // ****************************************
  // registers
  // ****************************************
  logic [31:0]    ctrl_reg;
  logic [6:0]     addr_reg;
  logic [7:0]     rdata_reg;
  logic           nack_reg;
  logic           go_reg;
  mx_host_state_e state_reg;
  logic           wb_req;

  function automatic logic [31:0] lanes(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    for (int b = 0; b < 4; b++)
    begin
      lanes[b*8 +: 8] = s[b] ? n[b*8 +: 8] : o[b*8 +: 8];
    end
  endfunction

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
      ctrl_reg <= '0;
      addr_reg <= TARGET_ADDR;
    end
    else
    begin
      wb_ack_o <= wb_req;
      wb_dat_o <= '0;
      if (wb_req && wb_we_i)
      begin
        if (wb_adr_i == WB_CTRL)
        begin
          ctrl_reg <= lanes(ctrl_reg, wb_dat_i, wb_sel_i);
        end
        else if (wb_adr_i == WB_ADDR)
        begin
          addr_reg <= 7'(lanes({25'h0, addr_reg}, wb_dat_i, wb_sel_i));
        end
      end
      else if (wb_req)
      begin
        if (wb_adr_i == WB_CTRL)
        begin
          wb_dat_o <= {ctrl_reg[31:1], 1'b0};
        end
        else if (wb_adr_i == WB_STAT)
        begin
          wb_dat_o[STAT_BUSY]         <= go_reg | (state_reg != HS_IDLE);
          wb_dat_o[STAT_NACK]         <= nack_reg;
          wb_dat_o[STAT_RDATA +: 8]   <= rdata_reg;
        end
        else if (wb_adr_i == WB_ADDR)
        begin
          wb_dat_o[6:0] <= addr_reg;
        end
      end
    end
  end

  // ****************************************
  // line synchronisers and quarter-bit tick
  // ****************************************
  logic [1:0] scl_sh_reg;
  logic [1:0] sda_sh_reg;
  logic [7:0] div_reg;
  logic       tick;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      scl_sh_reg <= 2'h3;
      sda_sh_reg <= 2'h3;
      div_reg    <= '0;
    end
    else
    begin
      scl_sh_reg <= {scl_sh_reg[0], link.scl};
      sda_sh_reg <= {sda_sh_reg[0], link.sda};
      div_reg    <= (state_reg == HS_IDLE || tick) ? 8'h00 : div_reg + 8'h01;
    end
  end

  assign tick = (state_reg != HS_IDLE) && (div_reg == QTR_LAST);

  // ****************************************
  // bit engine
  // ****************************************
  logic [1:0] q_reg;
  logic [3:0] bit_reg;
  logic [3:0] left_reg;
  logic [7:0] shift_reg;
  logic       tx_reg;
  logic       addr_ph_reg;
  logic       scl_oe_reg;
  logic       sda_oe_reg;
  logic       scl_h;
  logic       sda_h;
  logic [3:0] left_nx;

  assign scl_h   = scl_sh_reg[1];
  assign sda_h   = sda_sh_reg[1];
  assign left_nx = addr_ph_reg ? left_reg : left_reg - 4'h1;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg   <= HS_IDLE;
      go_reg      <= 1'b0;
      nack_reg    <= 1'b0;
      rdata_reg   <= '0;
      q_reg       <= '0;
      bit_reg     <= '0;
      left_reg    <= '0;
      shift_reg   <= '0;
      tx_reg      <= 1'b1;
      addr_ph_reg <= 1'b0;
      scl_oe_reg  <= 1'b0;
      sda_oe_reg  <= 1'b0;
    end
    else
    begin
      // go is refused while a transfer is pending or running
      if (wb_req && wb_we_i && wb_adr_i == WB_CTRL && wb_sel_i[0] &&
          wb_dat_i[CTRL_GO] && !go_reg && state_reg == HS_IDLE)
      begin
        go_reg   <= 1'b1;
        nack_reg <= 1'b0;
      end
      case (state_reg)
        HS_IDLE:
        begin
          if (go_reg && scl_h && sda_h)
          begin
            go_reg      <= 1'b0;
            shift_reg   <= {addr_reg, ctrl_reg[CTRL_RD]};
            left_reg    <= ctrl_reg[CTRL_CNT +: 4];
            tx_reg      <= 1'b1;
            addr_ph_reg <= 1'b1;
            bit_reg     <= '0;
            q_reg       <= '0;
            state_reg   <= HS_START;
          end
        end
        HS_START:
        begin
          if (tick)
          begin
            q_reg <= q_reg + 2'h1;
            if (q_reg == 2'h0)
            begin
              sda_oe_reg <= 1'b1;
            end
            else if (q_reg == 2'h1)
            begin
              scl_oe_reg <= 1'b1;
              q_reg      <= '0;
              state_reg  <= HS_BIT;
            end
          end
        end
        HS_BIT:
        begin
          // waits at the sample point while a target holds the clock low
          if (tick && !(q_reg == 2'h2 && !scl_h))
          begin
            q_reg <= q_reg + 2'h1;
            case (q_reg)
              2'h0:
              begin
                if (bit_reg != BYTE_BITS)
                begin
                  sda_oe_reg <= tx_reg & ~shift_reg[7];
                end
                else
                begin
                  sda_oe_reg <= ~tx_reg & (left_reg != 4'h1);
                end
              end
              2'h1:
              begin
                scl_oe_reg <= 1'b0;
              end
              2'h2:
              begin
                if (bit_reg != BYTE_BITS)
                begin
                  shift_reg <= {shift_reg[6:0], sda_h};
                end
                else if (tx_reg && sda_h)
                begin
                  nack_reg <= 1'b1;
                end
              end
              default:
              begin
                scl_oe_reg <= 1'b1;
                bit_reg    <= bit_reg + 4'h1;
                if (bit_reg == BYTE_BITS)
                begin
                  bit_reg     <= '0;
                  addr_ph_reg <= 1'b0;
                  left_reg    <= left_nx;
                  if (addr_ph_reg)
                  begin
                    tx_reg <= ~ctrl_reg[CTRL_RD];
                  end
                  if (!tx_reg)
                  begin
                    rdata_reg <= shift_reg;
                  end
                  shift_reg <= ctrl_reg[CTRL_WDATA +: 8];
                  if (nack_reg || left_nx == 4'h0)
                  begin
                    state_reg <= HS_STOP;
                  end
                end
              end
            endcase
          end
        end
        HS_STOP:
        begin
          if (tick)
          begin
            q_reg <= q_reg + 2'h1;
            if (q_reg == 2'h0)
            begin
              sda_oe_reg <= 1'b1;
            end
            else if (q_reg == 2'h1)
            begin
              scl_oe_reg <= 1'b0;
            end
            else if (q_reg == 2'h2)
            begin
              sda_oe_reg <= 1'b0;
            end
            else
            begin
              state_reg <= HS_IDLE;
            end
          end
        end
        default:
        begin
          state_reg <= HS_IDLE;
        end
      endcase
    end
  end

  assign link.scl_h_oe = scl_oe_reg;
  assign link.sda_h_oe = sda_oe_reg;

endmodule

// >>> mx_monitor.sv
`timescale 1ns/1ps
module mx_monitor #(
  parameter logic [6:0] ADDR = 7'h70
)(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       sda_d_oe,
  input  wire logic [7:0] channel_select_o,
  input  wire logic [1:0] active_o
);
  logic [3:0] bcnt;
  logic [3:0] since_stop;
  logic [7:0] shreg;
  logic       later;
  logic       more;
  logic       hit;
  logic       rw;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // ****************************************
  // frame tracking
  // ****************************************
  function automatic logic [1:0] dec(input logic [7:0] v);
    dec = (v[2] && !v[1]) ? (v[0] ? 2'b10 : 2'b01) : 2'b00;
  endfunction

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bcnt  <= 4'h0;
      later <= 1'b0;
      more  <= 1'b0;
      hit   <= 1'b0;
      rw    <= 1'b0;
      shreg <= 8'h00;
    end
    else if (scl && $past(scl) && $fell(sda))
    begin
      bcnt  <= 4'h0;
      later <= 1'b0;
    end
    else if ($rose(scl))
    begin
      if (bcnt == 4'h8)
      begin
        bcnt  <= 4'h0;
        later <= 1'b1;
        // a withheld ack means the next clock pulse belongs to the stop
        more  <= !later || !sda;
        if (!later)
        begin
          hit <= (shreg[7:1] == ADDR);
          rw  <= shreg[0];
        end
      end
      else
      begin
        shreg <= {shreg[6:0], sda};
        bcnt  <= bcnt + 4'h1;
      end
    end
  end

  // saturates so an old stop never excuses a late switch
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      since_stop <= 4'hf;
    else if (scl && $past(scl) && $rose(sda))
      since_stop <= 4'h0;
    else if (since_stop != 4'hf)
      since_stop <= since_stop + 4'h1;
  end

  // ****************************************
  // properties
  // ****************************************
  property p_one_hot;
    $onehot0(active_o);
  endproperty
  a_one_hot: assert property (p_one_hot) else $error("two channels on");
  property p_reset_clear;
    $fell(rst_i) |-> (active_o == 2'b00 && channel_select_o == 8'h00);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset state");
  property p_decode;
    $changed(active_o) |-> active_o == dec(channel_select_o);
  endproperty
  a_decode: assert property (p_decode) else $error("bad decode");
  property p_after_stop;
    $changed(active_o) |-> since_stop <= 4'h8;
  endproperty
  a_after_stop: assert property (p_after_stop) else $error("switch not after stop");
  property p_dev_stable;
    scl && $past(scl) |-> $stable(sda_d_oe);
  endproperty
  a_dev_stable: assert property (p_dev_stable) else $error("data moved in clock high");
  property p_addr_ack;
    $rose(scl) && bcnt == 4'h8 && !later |-> sda_d_oe == (shreg[7:1] == ADDR);
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address ack wrong");
  property p_wr_ack;
    $rose(scl) && bcnt == 4'h8 && later && hit && !rw |-> sda_d_oe;
  endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("data byte not acked");
  property p_rd_release;
    $rose(scl) && bcnt == 4'h8 && later && hit && rw |-> !sda_d_oe;
  endproperty
  a_rd_release: assert property (p_rd_release) else $error("data held in ack slot");
  property p_rd_data;
    $rose(scl) && bcnt != 4'h8 && later && more && hit && rw
      |-> sda_d_oe == !channel_select_o[3'h7 - bcnt[2:0]];
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("read bit wrong");
endmodule

// >>> tb.sv
`timescale 1ns/1ps
module tb;
  import mx_pkg::*;
  logic        clk_i;
  logic        rst_i;
  logic        wb_cyc;
  logic        wb_stb;
  logic        wb_we;
  logic [3:0]  wb_adr;
  logic [31:0] wb_dat_w;
  logic [31:0] wb_dat_r;
  logic        wb_ack;
  logic [1:0]  dclk_oe;
  logic [1:0]  ddat_oe;
  logic [1:0]  active;
  logic [7:0]  sel_reg;
  int          n_errors;
  int          n_checks;
  int          seed;
  int          lows [2];

  mx_link_if link_if();
  mx_host mx_host_inst(.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_w),
    .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack), .link(link_if));
  // downstream lines have pull-ups and no other driver
  mx_dev #(.ADDR(TARGET_ADDR)) mx_dev_inst(.clk_i(clk_i), .rst_i(rst_i), .up(link_if),
    .downstream_clock_i(~dclk_oe), .downstream_clock_o(), .downstream_clock_oe_o(dclk_oe),
    .downstream_data_i(~ddat_oe), .downstream_data_o(), .downstream_data_oe_o(ddat_oe),
    .channel_select_o(sel_reg), .active_o(active));
  mx_monitor #(.ADDR(TARGET_ADDR)) mx_monitor_inst(.clk_i(clk_i), .rst_i(rst_i),
    .scl(link_if.scl), .sda(link_if.sda), .sda_d_oe(link_if.sda_d_oe),
    .channel_select_o(sel_reg), .active_o(active));

  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  always @(posedge clk_i)
  begin
    lows[0] <= lows[0] + int'(dclk_oe[0]);
    lows[1] <= lows[1] + int'(dclk_oe[1]);
  end

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [1:0] exp_act(input logic [7:0] v);
    exp_act = (v[2] && !v[1]) ? (v[0] ? 2'b10 : 2'b01) : 2'b00;
  endfunction

  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_state(input logic [7:0] v);
    chk_val(32'(sel_reg), 32'(v), "select");
    chk_val(32'(active), 32'(exp_act(v)), "active");
  endtask

  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= we;
    wb_adr   <= a;
    wb_dat_w <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack !== 1'b1 && n < 50);
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    chk_val(32'(n < 50), 32'h1, "bus ack");
  endtask

  // polls status; a frame of two bytes needs some thousands of polls
  task automatic xfer(input logic [6:0] a, input logic rd, input logic [3:0] cnt,
                      input logic [7:0] wd, input logic [7:0] wd2, output logic [31:0] st);
    int n;
    logic [31:0] q;
    wb(1'b1, WB_ADDR, {25'h0, a}, q);
    wb(1'b1, WB_CTRL, ({24'h0, wd} << CTRL_WDATA) | ({28'h0, cnt} << CTRL_CNT)
                      | (32'(rd) << CTRL_RD) | 32'h1, q);
    repeat (4) @(posedge clk_i);
    n = 0;
    st = 32'h1;
    while (st[STAT_BUSY] !== 1'b0 && n < 8000)
    begin
      // reload lands while the first data byte of the frame is on the bus
      if (n == 2300 && wd2 !== wd)
      begin
        wb(1'b1, WB_CTRL, ({24'h0, wd2} << CTRL_WDATA) | ({28'h0, cnt} << CTRL_CNT)
                          | (32'(rd) << CTRL_RD), q);
      end
      wb(1'b0, WB_STAT, 32'h0, st);
      n++;
    end
    chk_val(32'(n < 8000), 32'h1, "frame done");
    repeat (10) @(posedge clk_i);
    chk_val(32'(link_if.scl & link_if.sda), 32'h1, "bus idle");
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    logic [31:0] st;
    logic [31:0] r;
    logic [7:0]  v;
    logic [2:0]  codes [4];
    int          l0;
    int          l1;
    seed = 32'h834e6a3d;
    rst_i = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 4'h0;
    wb_dat_w = 32'h0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    chk_state(8'h00);
    wb(1'b0, 4'hc, 32'h0, st);
    chk_val(st, 32'h0, "unmapped");
    r = $random(seed);
    codes[0] = {1'b0, r[1:0]};
    codes[1] = {2'b11, r[2]};
    codes[2] = 3'b100;
    codes[3] = 3'b101;
    for (int i = 0; i < 4; i++)
    begin
      r = $random(seed);
      v = {r[7:3], codes[i]};
      xfer(TARGET_ADDR, 1'b0, (i == 0) ? 4'h2 : 4'h1, (i == 0) ? ~v : v, v, st);
      chk_val(32'(st[STAT_NACK]), 32'h0, "write nack");
      chk_state(v);
    end
    l0 = lows[0];
    l1 = lows[1];
    xfer(TARGET_ADDR, 1'b1, 4'h2, 8'h00, 8'h00, st);
    chk_val(32'(st[STAT_RDATA +: 8]), 32'(v), "read back");
    chk_val(32'(lows[0] == l0), 32'h1, "idle channel quiet");
    chk_val(32'(lows[1] > l1), 32'h1, "traffic passed");
    xfer(TARGET_ADDR ^ 7'h01, 1'b0, 4'h1, 8'h04, 8'h04, st);
    chk_val(32'(st[STAT_NACK]), 32'h1, "foreign address");
    chk_state(v);
    // second reset in mid-run with a channel connected
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk_state(8'h00);
    stop_test();
  end

  initial
  begin
    repeat (95000) @(posedge clk_i);
    n_errors++;
    $display("ERROR %0t watchdog expired", $time);
    stop_test();
  end
endmodule
